/* File: include/tmr_pkg.sv */
// constants, register map and field layout of the 8-bit timer with shared prescaler
package tmr_pkg;

  // -------------------------------------------------------------------------
  // bus, prescaler, ratio and event widths
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PRE_W   = 8;
  localparam int unsigned RATIO_W = 3;
  localparam int unsigned EVT_W   = 3;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT     = 8'h01;
  localparam logic [7:0] OFS_INTCTL    = 8'h0b;
  localparam logic [7:0] OFS_OPTION    = 8'h81;
  localparam logic [7:0] OFS_PORTA_DIR = 8'h85;
  localparam logic [7:0] OFS_EVT_STS   = 8'h90;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h91;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int unsigned BIT_OVF_FLAG   = 2;
  localparam int unsigned BIT_OVF_IE     = 5;
  localparam int unsigned BIT_SRC_SEL    = 5;
  localparam int unsigned BIT_EDGE_SEL   = 4;
  localparam int unsigned BIT_PRE_ASSIGN = 3;
  localparam int unsigned RATIO_LSB      = 0;
  localparam int unsigned EVT_OVF        = 0;
  localparam int unsigned EVT_EXT        = 1;
  localparam int unsigned EVT_WDT        = 2;

  // -------------------------------------------------------------------------
  // reset values, direction mask and counts
  // -------------------------------------------------------------------------
  localparam logic [7:0]       RST_COUNT      = 8'h00;
  localparam logic [7:0]       RST_OPTION     = 8'hff;
  localparam logic [7:0]       RST_PORTA_DIR  = 8'h3f;
  localparam logic [7:0]       PORTA_DIR_MASK = 8'h3f;
  localparam logic [EVT_W-1:0] RST_EVT        = 3'h0;
  localparam logic [7:0]       COUNT_MAX      = 8'hff;
  localparam logic [1:0]       INHIBIT_CYCLES = 2'h2;

endpackage : tmr_pkg

/* File: include/tmr_link_if.sv */
// internal link between the timer core, its pin synchroniser and its prescaler
`timescale 1ns/1ns
interface tmr_link_if;
  logic       pin;
  logic       edge_sel;
  logic       edge_tick;
  logic       pre_tick_in;
  logic       pre_clear;
  logic       pre_assign;
  logic [2:0] pre_ratio;
  logic       pre_tick_out;

  modport core   (output pin, edge_sel, pre_tick_in, pre_clear, pre_assign, pre_ratio,
                  input  edge_tick, pre_tick_out);
  modport sync   (input  pin, edge_sel, output edge_tick);
  modport scaler (input  pre_tick_in, pre_clear, pre_assign, pre_ratio,
                  output pre_tick_out);
endinterface : tmr_link_if

/* File: hdl/tmr_edge_sync.sv */
// synchroniser and edge detector for the external count pin
`timescale 1ns/1ns
module tmr_edge_sync
  import tmr_pkg::*;
(
  input  logic          clk_i,
  input  logic          nrst_i,
  tmr_link_if.sync      lnk
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } tmr_sync_state_t;

  tmr_sync_state_t s_q;
  tmr_sync_state_t s_d;

  // two flops against metastability, a third for edge history
  always_comb
  begin
    s_d        = s_q;
    s_d.meta   = lnk.pin;
    s_d.stable = s_q.meta;
    s_d.prev   = s_q.stable;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // edge choice only looks at synchronised flops, never at the first one
  assign lnk.edge_tick = lnk.edge_sel ? (!s_q.stable && s_q.prev)
                                      : (s_q.stable && !s_q.prev);

endmodule : tmr_edge_sync

/* File: hdl/tmr_prescaler.sv */
// shared 8-bit prescaler with power-of-two tap select
`timescale 1ns/1ns
module tmr_prescaler
  import tmr_pkg::*;
(
  input  logic          clk_i,
  input  logic          nrst_i,
  tmr_link_if.scaler    lnk
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } tmr_pre_state_t;

  tmr_pre_state_t s_q;
  tmr_pre_state_t s_d;
  logic [3:0]     width;
  logic [8:0]     span;

  // count is internal only, there is no path to the register bus
  always_comb
  begin
    s_d = s_q;
    if (lnk.pre_clear)
      s_d.cnt = '0;
    else if (lnk.pre_tick_in)
      s_d.cnt = s_q.cnt + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // counter side divides by 2^(n+1), watchdog side by 2^n
  always_comb
  begin
    width = lnk.pre_assign ? {1'b0, lnk.pre_ratio}
                           : {1'b0, lnk.pre_ratio} + 4'h1;
    span  = (9'h001 << width) - 9'h001;
  end

  // a clear in the same cycle swallows the tick, so the ratio restarts cleanly
  assign lnk.pre_tick_out = lnk.pre_tick_in && !lnk.pre_clear
                            && ((s_q.cnt & span[7:0]) == span[7:0]);

endmodule : tmr_prescaler

/* File: hdl/tmr_top.sv */
// 8-bit timer/counter with shared prescaler, register port and interrupt
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module tmr_top
  import tmr_pkg::*;
(
  input  logic                      clk_i,
  input  logic                      nrst_i,
  input  logic [tmr_pkg::ADDR_W-1:0] addr_i,
  input  logic [tmr_pkg::DATA_W-1:0] wdata_i,
  input  logic                      wr_i,
  input  logic                      rd_i,
  output logic [tmr_pkg::DATA_W-1:0] rdata_o,
  input  logic                      external_count_pin_i,
  input  logic                      sleep_i,
  input  logic                      wdt_tick_i,
  input  logic                      watchdog_clear_i,
  output logic                      wdt_timeout_o,
  output logic                      irq_o
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       count_value;
    logic [1:0]       inhibit;
    logic             overflow_flag;
    logic             overflow_irq_enable;
    logic [7:0]       option_settings;
    logic [7:0]       port_a_direction;
    logic [EVT_W-1:0] evt_sts;
    logic [EVT_W-1:0] evt_mask;
    logic [7:0]       rdata;
    logic             wdt_timeout;
  } tmr_state_t;

  localparam tmr_state_t RST_STATE = '{
    count_value:         RST_COUNT,
    inhibit:             2'h0,
    overflow_flag:       1'b0,
    overflow_irq_enable: 1'b0,
    option_settings:     RST_OPTION,
    port_a_direction:    RST_PORTA_DIR,
    evt_sts:             RST_EVT,
    evt_mask:            RST_EVT,
    rdata:               8'h00,
    wdt_timeout:         1'b0
  };

  tmr_state_t s_q;
  tmr_state_t s_d;

  // -------------------------------------------------------------------------
  // submodules
  // -------------------------------------------------------------------------
  tmr_link_if lnk ();

  tmr_edge_sync u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .lnk    (lnk.sync)
  );

  tmr_prescaler u_pre (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .lnk    (lnk.scaler)
  );

  // -------------------------------------------------------------------------
  // decode and datapath terms
  // -------------------------------------------------------------------------
  logic             wr_count;
  logic             wr_intctl;
  logic             wr_option;
  logic             wr_porta;
  logic             wr_mask;
  logic             rd_sts;
  logic             count_source_select;
  logic             prescaler_assign;
  logic             src_tick;
  logic             inc;
  logic             ovf;
  logic             wdt_out;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] eff_mask;

  // register strobes
  always_comb
  begin
    wr_count  = wr_i && (addr_i == OFS_COUNT);
    wr_intctl = wr_i && (addr_i == OFS_INTCTL);
    wr_option = wr_i && (addr_i == OFS_OPTION);
    wr_porta  = wr_i && (addr_i == OFS_PORTA_DIR);
    wr_mask   = wr_i && (addr_i == OFS_EVT_MASK);
    rd_sts    = rd_i && (addr_i == OFS_EVT_STS);
  end

  // option fields are taken live, so a new assignment acts at once
  assign count_source_select = s_q.option_settings[BIT_SRC_SEL];
  assign prescaler_assign    = s_q.option_settings[BIT_PRE_ASSIGN];

  assign lnk.pin        = external_count_pin_i;
  assign lnk.edge_sel   = s_q.option_settings[BIT_EDGE_SEL];
  assign lnk.pre_assign = prescaler_assign;
  assign lnk.pre_ratio  = s_q.option_settings[RATIO_LSB +: RATIO_W];

  // counting source, frozen in sleep; the watchdog side keeps running
  always_comb
  begin
    src_tick = !sleep_i
               && (count_source_select ? lnk.edge_tick : 1'b1);
  end

  // only one user of the prescaler at a time, the other bypasses it
  always_comb
  begin
    lnk.pre_tick_in = prescaler_assign ? wdt_tick_i : src_tick;
    lnk.pre_clear   = prescaler_assign ? watchdog_clear_i : wr_count;
    wdt_out         = prescaler_assign ? lnk.pre_tick_out : wdt_tick_i;
  end

  // a fresh write holds the count still so the written value is seen intact
  always_comb
  begin
    inc = (s_q.inhibit == 2'h0)
          && (prescaler_assign ? src_tick : lnk.pre_tick_out);
    ovf = inc && (s_q.count_value == COUNT_MAX);
  end

  // event sources for the sticky status register
  always_comb
  begin
    evt_set          = '0;
    evt_set[EVT_OVF] = ovf;
    evt_set[EVT_EXT] = lnk.edge_tick && count_source_select && !sleep_i;
    evt_set[EVT_WDT] = wdt_out;
  end

  // overflow source also needs its own enable bit
  always_comb
  begin
    eff_mask          = s_q.evt_mask;
    eff_mask[EVT_OVF] = s_q.evt_mask[EVT_OVF] && s_q.overflow_irq_enable;
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    s_d             = s_q;
    s_d.wdt_timeout = wdt_out;

    // counter: a write beats an increment in the same cycle
    if (wr_count)
    begin
      s_d.count_value = wdata_i;
      s_d.inhibit     = INHIBIT_CYCLES;
    end
    else
    begin
      if (inc)
        s_d.count_value = s_q.count_value + 8'h01;
      if (s_q.inhibit != 2'h0)
        s_d.inhibit = s_q.inhibit - 2'h1;
    end

    // interrupt control: hardware only sets the flag, set wins over clear
    if (wr_intctl)
    begin
      s_d.overflow_flag       = wdata_i[BIT_OVF_FLAG];
      s_d.overflow_irq_enable = wdata_i[BIT_OVF_IE];
    end
    if (ovf)
      s_d.overflow_flag = 1'b1;

    // option and mask are plain storage; direction keeps only the PORTA_DIR_MASK bits
    if (wr_option)
      s_d.option_settings = wdata_i;
    if (wr_porta)
      s_d.port_a_direction = wdata_i & PORTA_DIR_MASK;
    if (wr_mask)
      s_d.evt_mask = wdata_i[EVT_W-1:0];

    // status clears on read, but an event in that cycle survives
    s_d.evt_sts = (rd_sts ? '0 : s_q.evt_sts) | evt_set;

    // read data for the next cycle; unmapped offsets return zero
    s_d.rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        OFS_COUNT:
        begin
          s_d.rdata = s_q.count_value;
        end
        OFS_INTCTL:
        begin
          s_d.rdata[BIT_OVF_FLAG] = s_q.overflow_flag;
          s_d.rdata[BIT_OVF_IE]   = s_q.overflow_irq_enable;
        end
        OFS_OPTION:
        begin
          s_d.rdata = s_q.option_settings;
        end
        OFS_PORTA_DIR:
        begin
          s_d.rdata = s_q.port_a_direction;
        end
        OFS_EVT_STS:
        begin
          s_d.rdata[EVT_W-1:0] = s_q.evt_sts;
        end
        OFS_EVT_MASK:
        begin
          s_d.rdata[EVT_W-1:0] = s_q.evt_mask;
        end
        default:
        begin
          s_d.rdata = 8'h00;  // prescaler count is deliberately absent
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      s_q <= RST_STATE;
    else
      s_q <= s_d;
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign rdata_o       = s_q.rdata;
  assign wdt_timeout_o = s_q.wdt_timeout;
  assign irq_o         = |(s_q.evt_sts & eff_mask);

endmodule : tmr_top

/* File: bench/tmr_top_props.sv */
// concurrent checks on the timer block ports
`timescale 1ns/1ns
module tmr_top_props
  import tmr_pkg::*;
(
  input logic                       clk_i,
  input logic                       nrst_i,
  input logic [tmr_pkg::ADDR_W-1:0] addr_i,
  input logic [tmr_pkg::DATA_W-1:0] wdata_i,
  input logic                       wr_i,
  input logic                       rd_i,
  input logic [tmr_pkg::DATA_W-1:0] rdata_o,
  input logic                       sleep_i,
  input logic                       wdt_tick_i,
  input logic                       wdt_timeout_o,
  input logic                       irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic mapped;
  // decoded places; anything else must read back as zero
  assign mapped = addr_i inside {OFS_COUNT, OFS_INTCTL, OFS_OPTION, OFS_PORTA_DIR,
    OFS_EVT_STS, OFS_EVT_MASK};
  // ----
  // named bus steps
  // ----
  sequence s_wr_cnt;
    wr_i && addr_i == OFS_COUNT;
  endsequence
  sequence s_rd_cnt;
    rd_i && addr_i == OFS_COUNT;
  endsequence
  sequence s_rd_slp;
    rd_i && addr_i == OFS_COUNT && sleep_i;
  endsequence
  // ----
  // checks
  // ----
  chk_unmapped_zero : assert property (
    rd_i && !mapped |=> rdata_o == 8'h00) else $error("unmapped read gave data");
  chk_wr_hold_one : assert property (
    s_wr_cnt ##1 s_rd_cnt |=> rdata_o == $past(wdata_i, 2)) else $error("count moved early");
  chk_wr_hold_two : assert property (
    s_wr_cnt ##1 !wr_i ##1 s_rd_cnt |=> rdata_o == $past(wdata_i, 3))
    else $error("count moved in second blocked cycle");
  chk_wr_hold_three : assert property (
    s_wr_cnt ##1 !wr_i ##1 !wr_i ##1 s_rd_cnt |=> rdata_o == $past(wdata_i, 4))
    else $error("count moved before third cycle");
  chk_sleep_frozen : assert property (
    s_rd_slp ##1 s_rd_slp |=> rdata_o == $past(rdata_o)) else $error("count moved in sleep");
  chk_wdt_cause : assert property (
    wdt_timeout_o |-> $past(wdt_tick_i)) else $error("watchdog pulse without tick");
  chk_opt_back : assert property (
    wr_i && addr_i == OFS_OPTION ##1 rd_i && addr_i == OFS_OPTION
    |=> rdata_o == $past(wdata_i, 2)) else $error("option readback wrong");
  chk_irq_sticky : assert property (
    irq_o && !wr_i && !(rd_i && addr_i == OFS_EVT_STS) |=> irq_o)
    else $error("interrupt dropped by itself");
  chk_irq_masked : assert property (
    wr_i && addr_i == OFS_EVT_MASK && wdata_i[2:0] == 3'h0 |=> !irq_o)
    else $error("masked interrupt still high");
endmodule : tmr_top_props

/* File: bench/tmr_pin_model.sv */
// external count pin source: bursts of pulses on request
`timescale 1ns/1ns
module tmr_pin_model
(
  input  logic       clk_i,
  input  logic       start_i,
  input  logic [7:0] n_i,
  input  logic [7:0] hi_i,
  output logic       pin_o,
  output logic       busy_o
);
  int k;
  // pin rests low between bursts; each level is held hi_i cycles
  initial
  begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (start_i)
      begin
        busy_o <= 1'b1;
        for (k = 0; k < n_i; k++)
        begin
          pin_o <= 1'b1;
          repeat (hi_i) @(posedge clk_i);
          pin_o <= 1'b0;
          repeat (hi_i) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : tmr_pin_model

/* File: bench/test_tmr_top.sv */
// self-checking bench for the timer block
`timescale 1ns/1ns
module test_tmr_top;
  import tmr_pkg::*;
  logic       clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0;
  logic       wdt_tick_i = 1'b0, watchdog_clear_i = 1'b0, start = 1'b0, pend = 1'b0;
  logic       pin, busy, wdt_timeout_o, irq_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, n = 8'h03, hi = 8'h14;
  logic [7:0] rdata_o, last_rd, d1;
  int         error_cnt = 0, checks_done = 0, seed = 35, to_cnt = 0, t, r, d0, e;
  int         exp_q[$];

  tmr_top i_tmr_top (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .external_count_pin_i(pin), .sleep_i, .wdt_tick_i, .watchdog_clear_i, .wdt_timeout_o,
    .irq_o);
  tmr_pin_model i_tmr_pin_model (.clk_i, .start_i(start), .n_i(n), .hi_i(hi),
    .pin_o(pin), .busy_o(busy));

  initial
    forever #2 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] ex);
    checks_done++;
    if (seen !== ex)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  // strobes are left up so a next access may follow with no gap
  task automatic bus(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d);
    wr_i <= w;
    rd_i <= rr;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  // a negative note means the data are only captured, not compared
  task automatic rd(input logic [7:0] a, input int ex);
    exp_q.push_back(ex);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle();
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : idle
  task automatic irq_is(input logic ex);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge clk_i);
    check("irq", {7'h00, irq_o}, {7'h00, ex});
    @(posedge clk_i);
  endtask : irq_is
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ----
  // result watcher: read data stand only in the cycle after the strobe
  // ----
  always @(posedge clk_i)
    pend <= rd_i;
  always @(negedge clk_i)
  begin
    if (pend)
    begin
      last_rd = rdata_o;
      e = exp_q.pop_front();
      if (e >= 0)
        check("rdata", rdata_o, e[7:0]);
    end
    if (wdt_timeout_o === 1'b1)
      to_cnt++;
  end

  // whole run is about two thousand cycles; this limit is far past it
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end

  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(OFS_OPTION, 8'hff);
    rd(OFS_PORTA_DIR, 8'h3f);
    rd(OFS_INTCTL, 8'h00);
    rd(OFS_COUNT, 8'h00);
    rd(8'h02, 8'h00);
    wr(OFS_PORTA_DIR, 8'hc5);
    rd(OFS_PORTA_DIR, 8'h05);
    wr(OFS_OPTION, 8'h08);
    rd(OFS_OPTION, 8'h08);
    wr(OFS_COUNT, 8'h10);
    for (t = 0; t < 4; t++)
      rd(OFS_COUNT, t < 3 ? 8'h10 : 8'h0e + t);
    wr(OFS_EVT_MASK, 8'h01);
    wr(OFS_INTCTL, 8'h20);
    wr(OFS_COUNT, 8'hfe);
    idle();
    repeat (4) @(posedge clk_i);
    rd(OFS_INTCTL, 8'h24);
    irq_is(1'b1);
    rd(OFS_EVT_STS, 8'h01);
    irq_is(1'b0);
    wr(OFS_INTCTL, 8'h00);
    wr(OFS_COUNT, 8'hfe);
    idle();
    repeat (6) @(posedge clk_i);
    rd(OFS_INTCTL, 8'h04);
    irq_is(1'b0);
    rd(OFS_EVT_STS, 8'h01);
    wr(OFS_INTCTL, 8'h00);
    wr(OFS_INTCTL, 8'h20);
    irq_is(1'b0);
    sleep_i <= 1'b1;
    wr(OFS_COUNT, 8'h50);
    idle();
    repeat (6) @(posedge clk_i);
    rd(OFS_COUNT, 8'h50);
    rd(OFS_COUNT, 8'h50);
    sleep_i <= 1'b0;
    for (r = 0; r < 8; r++)
    begin
      wr(OFS_OPTION, {5'h00, r[2:0]});
      wr(OFS_COUNT, 8'h00);
      idle();
      repeat ((1 << r) + 2) @(posedge clk_i);
      // write clears the prescaler, so the first step lands after 2^(r+1) cycles, after 4 for r = 0 as the hold blocks the tick at 2
      rd(OFS_COUNT, r < 2 ? 1 : 0);
      idle();
      d1 = last_rd;
      repeat ((4 << r) - 2) @(posedge clk_i);
      rd(OFS_COUNT, -1);
      idle();
      check("steps", last_rd - d1, 8'h02);
    end
    to_cnt = 0;
    wdt_tick_i <= 1'b1;
    @(posedge clk_i);
    wdt_tick_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("wdt", to_cnt[7:0], 8'h01);
    for (r = 0; r < 2; r++)
    begin
      wr(OFS_OPTION, r ? 8'h38 : 8'h28);
      wr(OFS_COUNT, 8'h00);
      rd(OFS_EVT_STS, -1);
      start <= 1'b1;
      idle();
      start <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(OFS_COUNT, r ? 0 : 1);
      idle();
      repeat (130) @(posedge clk_i);
      check("burst", {7'h00, busy}, 8'h00);
      rd(OFS_COUNT, 8'h03);
      rd(OFS_EVT_STS, 8'h02);
    end
    wr(OFS_COUNT, 8'h00);
    for (r = 0; r < 4; r++)
    begin
      wr(OFS_OPTION, 8'h08 | r[7:0]);
      watchdog_clear_i <= 1'b1;
      idle();
      watchdog_clear_i <= 1'b0;
      to_cnt = 0;
      t = 0;
      // one tick short of four periods, so a missed clear shows as a fourth pulse
      while (t < (4 << r) - 1)
      begin
        d0 = $random(seed) & 1;
        wdt_tick_i <= d0[0];
        t += d0;
        @(posedge clk_i);
      end
      wdt_tick_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("wdt", to_cnt[7:0], 8'h03);
    end
    rd(OFS_EVT_STS, -1);
    idle();
    check("wdt_evt", {7'h00, last_rd[EVT_WDT]}, 8'h01);
    wr(OFS_EVT_MASK, 8'h00);
    idle();
    finish_test();
  end
endmodule : test_tmr_top

bind tmr_top tmr_top_props i_tmr_top_props (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .sleep_i, .wdt_tick_i, .wdt_timeout_o, .irq_o);
